// ==== tb_tcp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_tcp_top;
  import tcp_pkg::*;
  typedef struct {logic [31:0] e; bit chk; string nm;} tcp_note_s;
  logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, ext_count_input;
  logic sleep, watchdog_tick, watchdog_clear, watchdog_scaled_tick, irq;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] x;
  tcp_note_s notes[$];
  tcp_note_s nt;
  int n_fail = 0;
  int comparisons = 0;
  int wd_cnt = 0;

  tcp_top tcp_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_count_input(ext_count_input), .sleep(sleep),
    .watchdog_tick(watchdog_tick), .watchdog_clear(watchdog_clear),
    .watchdog_scaled_tick(watchdog_scaled_tick), .irq(irq));
  tcp_pulse_src tcp_pulse_src_i (.clk_sys(clk_sys), .pin(ext_count_input));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // --------------------------------------------
  // Bus access: three cycles, read samples at start+1
  // --------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, input bit chk, input logic [31:0] e, input string nm);
    int i;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (!w) notes.push_back('{e, chk, nm});
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_fail++;
      final_report();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, 1'b0, 32'h0, "");
  endtask : wr

  task automatic rdc(input logic [3:0] a, input bit chk, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, 4'hf, chk, e, nm);
  endtask : rdc

  task automatic ticks(input int n);
    repeat (n) begin
      watchdog_tick <= 1'b1;
      @(posedge clk_sys);
      watchdog_tick <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : ticks

  // Monitor: each completed read pops the oldest note and is compared with it when its chk bit is set
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (notes.size() == 0) check("note queue", 32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        if (nt.chk) check(nt.nm, avs_readdata, nt.e);
      end
    end
  end

  always @(posedge clk_sys) if (watchdog_scaled_tick === 1'b1) wd_cnt++;

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, sleep, watchdog_tick, watchdog_clear} = 5'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    void'($urandom(40));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // Reset values and refused accesses
    rdc(ADDR_OPTION, 1, 32'h3f, "option reset");
    rdc(ADDR_STATUS, 1, 32'h0, "status reset");
    rdc(ADDR_MASK, 1, 32'h0, "mask reset");
    rdc(ADDR_COUNT, 1, 32'h0, "count reset");
    rdc(4'h2, 1, 32'h0, "unmapped read");
    bus(1'b1, ADDR_OPTION, 32'h08, 4'h0, 1'b0, 32'h0, "");
    wr(4'h1, 32'h08);
    rdc(ADDR_OPTION, 1, 32'h3f, "option kept");
    $display("test reset done");
    // Timer mode, write inhibit
    wr(ADDR_OPTION, 32'h08);
    for (int j = 3; j < 16; j += 4) begin
      x = 8'($urandom_range(200, 0));
      wr(ADDR_COUNT, {24'h0, x});
      repeat (4 * j - 1) @(posedge clk_sys);
      rdc(ADDR_COUNT, 1, {24'h0, x + 8'(j) - 8'd2}, "count after write");
    end
    rdc(ADDR_COUNT, 0, 32'h0, "");
    repeat (37) @(posedge clk_sys);
    rdc(ADDR_COUNT, 1, {24'h0, rd[7:0] + 8'd10}, "count rate");
    sleep <= 1'b1;
    rdc(ADDR_COUNT, 0, 32'h0, "");
    repeat (37) @(posedge clk_sys);
    rdc(ADDR_COUNT, 1, rd, "count in sleep");
    sleep <= 1'b0;
    $display("test timer done");
    // Prescaler ratios
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_OPTION, 32'(k));
      rdc(ADDR_COUNT, 0, 32'h0, "");
      repeat (8 * (2 << k) - 3) @(posedge clk_sys);
      rdc(ADDR_COUNT, 1, {24'h0, rd[7:0] + 8'd2}, "prescaled rate");
    end
    $display("test prescaler done");
    // Overflow flag and interrupt
    wr(ADDR_OPTION, 32'h08);
    wr(ADDR_COUNT, 32'hfd);
    repeat (40) @(posedge clk_sys);
    rdc(ADDR_STATUS, 1, 32'h1, "flag masked");
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(ADDR_MASK, 32'h1);
    check("irq enabled", {31'h0, irq}, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc(ADDR_STATUS, 1, 32'h0, "flag cleared");
    wr(ADDR_MASK, 32'h0);
    $display("test overflow done");
    // Counter mode: rising, falling, prescaled 1:2
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_OPTION, 32'h20 | (c == 1 ? 32'h10 : 32'h0) | (c == 2 ? 32'h0 : 32'h08));
      wr(ADDR_COUNT, 32'h0);
      repeat (16) @(posedge clk_sys);
      tcp_pulse_src_i.pulses(5);
      tcp_pulse_src_i.level(1'b1);
      repeat (24) @(posedge clk_sys);
      rdc(ADDR_COUNT, 1, (c == 0) ? 32'h6 : (c == 1) ? 32'h5 : 32'h3, "edge count");
      tcp_pulse_src_i.level(1'b0);
    end
    $display("test counter done");
    // Watchdog share of the prescaler
    wr(ADDR_OPTION, 32'h0b);
    watchdog_clear <= 1'b1;
    @(posedge clk_sys);
    watchdog_clear <= 1'b0;
    wd_cnt = 0;
    ticks(24);
    check("scaled ticks", 32'(wd_cnt), 32'h3);
    wr(ADDR_OPTION, 32'h00);
    wd_cnt = 0;
    ticks(8);
    check("ticks while owned", 32'(wd_cnt), 32'h0);
    $display("test watchdog done");
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : tb_tcp_top
`default_nettype wire

// ==== tcp_pkg.sv ====
package tcp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_OPTION = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hc;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPT_SOURCE_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int STAT_OVERFLOW_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic MASK_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_TWO = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

  typedef struct packed {
    logic count_source_select;
    logic count_edge_select;
    logic divider_assign;
    logic [2:0] divider_rate;
  } tcp_option_s;

endpackage : tcp_pkg

// ==== tcp_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcp_prescaler
  import tcp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic step,
  input wire logic clear,
  input wire logic wdt_mode,
  input wire logic [2:0] divider_rate,
  output logic [WIDTH-1:0] value,
  output logic carry
);

  // Ratio mask: counter side 1:2..1:256, watchdog side 1:1..1:128
  function automatic logic [WIDTH-1:0] rate_mask(input logic [2:0] rate, input logic wdt);
    logic [WIDTH:0] m;
    m = wdt ? ((WIDTH+1)'(1) << rate) : ((WIDTH+1)'(2) << rate);
    rate_mask = WIDTH'(m - (WIDTH+1)'(1));
  endfunction : rate_mask

  assign carry = step && ((value & rate_mask(divider_rate, wdt_mode)) == rate_mask(divider_rate, wdt_mode));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      value <= '0;
    end else if (clear) begin
      value <= '0;
    end else if (step) begin
      value <= value + WIDTH'(1);
    end
  end

  a_rate_carry: assert property (@(posedge clk_sys) disable iff (!reset_n)
    carry |=> (value & rate_mask(divider_rate, wdt_mode)) == '0 || $past(clear))
    else $error("prescaler carry without wrap of rate bits");

endmodule : tcp_prescaler
`default_nettype wire

// ==== tcp_pulse_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcp_pulse_src (
  input wire logic clk_sys,
  output var logic pin
);
  initial pin = 1'b0;

  // Whole pulses, each level held 8 to 15 clocks
  task automatic pulses(input int n);
    for (int k = 0; k < n; k++) begin
      repeat ($urandom_range(15, 8)) @(posedge clk_sys);
      pin <= 1'b1;
      repeat ($urandom_range(15, 8)) @(posedge clk_sys);
      pin <= 1'b0;
    end
  endtask : pulses

  // Full level time before the change as well
  task automatic level(input logic v);
    repeat (16) @(posedge clk_sys);
    pin <= v;
    repeat (16) @(posedge clk_sys);
  endtask : level
endmodule : tcp_pulse_src
`default_nettype wire

// ==== tcp_top.sv ====
// Function
// - Count register wraps from ff to 00 and sets the overflow flag.
// - Source select zero picks the internal instruction cycle clock.
// - Timer mode without prescaler counts once every instruction cycle.
// - A write to the count register blocks counting for two instruction cycles.
// - Source select one counts edges of the external count input.
// - Edge select zero counts rising edges, one counts falling edges.
// - Overflow interrupt is raised only while its enable bit is set.
// - Counting halts during sleep, so overflow cannot wake the core.
// - External path is sampled on phase two and phase four of each cycle.
// - Without prescaler the external input feeds the synchroniser directly.
// - One prescaler is shared with the watchdog, owned by one at once.
// - Assign bit zero gives prescaler to counter, one to watchdog.
// - Three-bit rate sets counter ratio 1:2 at 000 up to 1:256 at 111, watchdog ratio 1:1 up to 1:128.
// - Count writes clear the owned prescaler; prescaler is not software visible.
`timescale 1ns/1ps
`default_nettype none
module tcp_top
  import tcp_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_count_input,
  input wire logic sleep,
  input wire logic watchdog_tick,
  input wire logic watchdog_clear,
  output logic watchdog_scaled_tick,
  output logic irq
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack;
  logic bus_req;
  logic wr_take;
  logic lane0;
  logic [7:0] count_register;
  tcp_option_s option;
  logic overflow_flag;
  logic overflow_irq_enable;

  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack;
  assign wr_take = avs_write && ack;
  assign lane0 = avs_byteenable[0];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req && !ack;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      case (avs_address)
        ADDR_COUNT: avs_readdata <= {24'h000000, count_register};
        ADDR_OPTION: avs_readdata <= {26'h0000000, option};
        ADDR_STATUS: avs_readdata <= 32'(overflow_flag) << STAT_OVERFLOW_BIT;
        ADDR_MASK: avs_readdata <= 32'(overflow_irq_enable) << STAT_OVERFLOW_BIT;
        default: avs_readdata <= '0;
      endcase
    end
  end

  logic count_wr;
  logic status_clr;
  assign count_wr = wr_take && lane0 && (avs_address == ADDR_COUNT);
  assign status_clr = wr_take && lane0 && (avs_address == ADDR_STATUS) && avs_writedata[STAT_OVERFLOW_BIT];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      option <= tcp_option_s'(OPTION_RESET[5:0]);
    end else if (wr_take && lane0 && avs_address == ADDR_OPTION) begin
      option <= tcp_option_s'(avs_writedata[5:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overflow_irq_enable <= MASK_RESET;
    end else if (wr_take && lane0 && avs_address == ADDR_MASK) begin
      overflow_irq_enable <= avs_writedata[STAT_OVERFLOW_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Instruction cycle phases
  // ----------------------------------------------------------------
  logic [1:0] phase;
  logic q2_en;
  logic q4_en;
  assign q2_en = phase == PHASE_TWO;
  assign q4_en = phase == PHASE_FOUR;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase <= '0;
    end else begin
      phase <= 2'(phase + 2'd1);
    end
  end

  // ----------------------------------------------------------------
  // External input conditioning
  // ----------------------------------------------------------------
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_level;
  logic ext_pol;
  logic ext_edge;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_level <= 1'b0;
    end else begin
      ext_s1 <= ext_count_input;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_level <= ext_s3;
      end
    end
  end

  // Polarity flip turns the selected edge into a rising one
  assign ext_pol = ext_level ^ option.count_edge_select;
  assign ext_edge = (ext_s3 ^ option.count_edge_select) && !ext_pol && (ext_s2 == ext_s3);

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  logic to_counter;
  logic pre_step;
  logic pre_clear;
  logic pre_carry;
  logic [PRESCALE_WIDTH-1:0] pre_value;
  logic instr_tick;

  assign instr_tick = q4_en;
  assign to_counter = !option.divider_assign;
  always_comb begin
    if (to_counter) begin
      pre_step = !sleep && (option.count_source_select ? ext_edge : instr_tick);
      pre_clear = count_wr;
    end else begin
      pre_step = watchdog_tick;
      pre_clear = watchdog_clear;
    end
  end
  assign watchdog_scaled_tick = !to_counter && pre_carry;

  tcp_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .step(pre_step),
    .clear(pre_clear),
    .wdt_mode(option.divider_assign),
    .divider_rate(option.divider_rate),
    .value(pre_value),
    .carry(pre_carry)
  );

  // ----------------------------------------------------------------
  // Phase-two / phase-four synchroniser of the counter-mode path
  // ----------------------------------------------------------------
  logic pre_level;
  logic samp_q2;
  logic samp_q4;
  assign pre_level = to_counter ? pre_value[option.divider_rate] : ext_pol;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      // Match the polarised idle level, no false edge after reset
      samp_q2 <= OPTION_RESET[OPT_EDGE_BIT];
      samp_q4 <= OPTION_RESET[OPT_EDGE_BIT];
    end else begin
      if (q2_en) begin
        samp_q2 <= pre_level;
      end
      if (q4_en) begin
        samp_q4 <= samp_q2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  logic [1:0] inhibit;
  logic inc_raw;
  logic inc;
  logic wrap;

  always_comb begin
    if (option.count_source_select) begin
      inc_raw = q4_en && samp_q2 && !samp_q4;
    end else begin
      inc_raw = to_counter ? (instr_tick && pre_carry) : instr_tick;
    end
  end
  assign inc = inc_raw && !sleep && inhibit == 2'd0;
  assign wrap = inc && count_register == 8'hff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inhibit <= '0;
    end else if (count_wr) begin
      inhibit <= INHIBIT_CYCLES;
    end else if (instr_tick && inhibit != 2'd0) begin
      inhibit <= 2'(inhibit - 2'd1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_register <= COUNT_RESET;
    end else if (count_wr) begin
      count_register <= avs_writedata[7:0];
    end else if (inc) begin
      count_register <= 8'(count_register + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (status_clr) begin
      overflow_flag <= 1'b0;
    end
  end

  assign irq = overflow_flag && overflow_irq_enable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wrap_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wrap && !count_wr |=> count_register == 8'h00 && overflow_flag)
    else $error("wrap did not clear count and set flag");

  a_flag_always_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wrap && !overflow_irq_enable ##1 !status_clr [*2] |-> overflow_flag)
    else $error("flag lost while interrupt disabled");

  a_timer_direct: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !option.count_source_select && option.divider_assign && !sleep && inhibit == 2'd0
    && instr_tick && !count_wr |=> count_register == 8'($past(count_register) + 8'h01))
    else $error("timer mode missed an instruction cycle");

  a_write_inhibit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    inhibit != 2'd0 && !count_wr |=> $stable(count_register))
    else $error("count moved during write inhibit");

  a_inhibit_ends: assert property (@(posedge clk_sys) disable iff (!reset_n)
    count_wr ##1 !count_wr [*8] |=> inhibit == 2'd0)
    else $error("inhibit outlived two instruction cycles");

  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !overflow_irq_enable |-> !irq)
    else $error("interrupt raised while masked");

  a_sleep_halt: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sleep && !count_wr |=> $stable(count_register) && !$rose(overflow_flag))
    else $error("count advanced during sleep");

  a_phase_sample: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(samp_q4) |-> $past(q4_en) && samp_q4 == $past(samp_q2))
    else $error("synchroniser sampled off phase");

  a_direct_path: assert property (@(posedge clk_sys) disable iff (!reset_n)
    option.divider_assign && q2_en |=> samp_q2 == $past(ext_pol))
    else $error("external level not passed straight through");

  a_edge_pick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ext_edge |=> ext_level == !option.count_edge_select || $past(option) != option)
    else $error("counted edge has wrong polarity");

  a_owner_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !to_counter |-> pre_step == watchdog_tick && (option.count_source_select || inc_raw == instr_tick))
    else $error("counter used a prescaler owned by the watchdog");

  a_write_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    count_wr && to_counter |=> pre_value == '0)
    else $error("count write left prescaler uncleared");

  c_overflow: cover property (@(posedge clk_sys) disable iff (!reset_n) wrap && overflow_irq_enable);
  c_ext_count: cover property (@(posedge clk_sys) disable iff (!reset_n) inc && option.count_source_select);
  c_prescaled: cover property (@(posedge clk_sys) disable iff (!reset_n)
    inc && to_counter && !option.count_source_select);
  c_set_clear: cover property (@(posedge clk_sys) disable iff (!reset_n) wrap && status_clr);

endmodule : tcp_top
`default_nettype wire
